// [rtl/asram_cfg.svh]
`ifndef ASRAM_CFG_SVH
`define ASRAM_CFG_SVH
// all times in ns except the retention recovery (ms)
`define ASRAM_CLK_NS        10
`define ASRAM_T_ACC_NS      70
`define ASRAM_T_OE_NS       35
`define ASRAM_T_DIS_NS      25
`define ASRAM_T_WC_NS       70
`define ASRAM_T_WP_NS       55
`define ASRAM_T_ASU_WH_NS   65
`define ASRAM_T_DSU_NS      30
`define ASRAM_T_REC_PD_MS   5
// least times round up to whole cycles
`define ASRAM_CYC_UP(t)     (((t) + `ASRAM_CLK_NS - 1) / `ASRAM_CLK_NS)
`define ASRAM_ACC_CYC       (`ASRAM_CYC_UP(`ASRAM_T_ACC_NS) + 1)
`define ASRAM_DIS_CYC       `ASRAM_CYC_UP(`ASRAM_T_DIS_NS)
`define ASRAM_WP_CYC        `ASRAM_CYC_UP(`ASRAM_T_WP_NS)
`define ASRAM_WC_CYC        `ASRAM_CYC_UP(`ASRAM_T_WC_NS)
`define ASRAM_DSU_CYC       `ASRAM_CYC_UP(`ASRAM_T_DSU_NS)
`define ASRAM_REC_PD_CYC    (`ASRAM_T_REC_PD_MS * 1000000 / `ASRAM_CLK_NS)
`endif

// [rtl/asram_pkg.sv]
package asram_pkg;
	typedef enum logic [2:0] {
		ASRAM_IDLE,
		ASRAM_RD,
		ASRAM_WR_SETUP,
		ASRAM_WR_PULSE,
		ASRAM_WR_END,
		ASRAM_TURN,
		ASRAM_SLEEP,
		ASRAM_WAKE
	} asram_state_t;

	typedef struct packed {
		logic cs1_n;
		logic cs2;
		logic we_n;
		logic oe_n;
	} asram_ctl_t;
endpackage

// [rtl/asram_ctrl.sv]
// Operation
// - write cycle 70 ns, strobe low 55 ns, address stable 65 ns
// - controller never drives data while memory drives it
// - deselect before retention, wait 5 ms after wake before access
// - during retention active-high select held firm
`timescale 1ns/10ps
`include "asram_cfg.svh"
module asram_ctrl
	import asram_pkg::*;
#(
	parameter int AW          = 17,
	parameter int DW          = 8,
	parameter int REC_PD_CYC  = `ASRAM_REC_PD_CYC
) (
	input  wire logic          mclk_i,
	input  wire logic          sys_rst_i,
	input  wire logic          req_i,
	input  wire logic          req_wr_i,
	input  wire logic [AW-1:0] req_addr_i,
	input  wire logic [DW-1:0] req_wdata_i,
	input  wire logic          sleep_i,
	output logic               busy_o,
	output logic               rd_valid_o,
	output logic [DW-1:0]      rd_data_o,
	output logic               asleep_o,
	output logic [AW-1:0]      mem_addr_o,
	output logic               mem_cs1_n_o,
	output logic               mem_cs2_o,
	output logic               mem_we_n_o,
	output logic               mem_oe_n_o,
	output logic [DW-1:0]      mem_dq_o,
	output logic               mem_dq_oe_o,
	input  wire logic [DW-1:0] mem_dq_i
);

	////////////////////////////////////////////////////////////////////////
	localparam int CW = 20;
	localparam logic [CW-1:0] ACC_C  = CW'(`ASRAM_ACC_CYC);
	localparam logic [CW-1:0] DIS_C  = CW'(`ASRAM_DIS_CYC);
	localparam logic [CW-1:0] WP_C   = CW'(`ASRAM_WP_CYC);
	localparam logic [CW-1:0] WC_C   = CW'(`ASRAM_WC_CYC);
	localparam logic [CW-1:0] REC_C  = CW'(REC_PD_CYC);
	localparam logic [CW-1:0] DSU_C  = CW'(`ASRAM_DSU_CYC);
	// cs2 never moves, so retention rests on cs1_n alone
	localparam asram_ctl_t    CTL_OFF = '{cs1_n: 1'b1, cs2: 1'b1, we_n: 1'b1, oe_n: 1'b1};
	localparam asram_ctl_t    CTL_RD  = '{cs1_n: 1'b0, cs2: 1'b1, we_n: 1'b1, oe_n: 1'b0};
	localparam asram_ctl_t    CTL_WR  = '{cs1_n: 1'b0, cs2: 1'b1, we_n: 1'b1, oe_n: 1'b1};

	////////////////////////////////////////////////////////////////////////
	asram_state_t    st_r, st_nxt;
	logic [CW-1:0]   cnt_r, cnt_nxt;
	asram_ctl_t      ctl_r, ctl_nxt;
	logic [AW-1:0]   addr_r, addr_nxt;
	logic [DW-1:0]   wd_r, wd_nxt;
	logic            dqoe_r, dqoe_nxt;
	logic [DW-1:0]   rdat_r, rdat_nxt;
	logic            rval_r, rval_nxt;
	logic            busy_r, busy_nxt;
	logic            slp_r, slp_nxt;
	logic            rd_take;

	always_comb begin
		st_nxt   = st_r;
		cnt_nxt  = (cnt_r != '0) ? cnt_r - CW'(1) : cnt_r;
		ctl_nxt  = ctl_r;
		addr_nxt = addr_r;
		wd_nxt   = wd_r;
		dqoe_nxt = dqoe_r;
		busy_nxt = busy_r;
		slp_nxt  = slp_r;
		case (st_r)
			ASRAM_IDLE: begin
				busy_nxt = 1'b0;
				if (sleep_i) begin
					// deselect already holds, so retention setup is met
					ctl_nxt  = CTL_OFF;
					slp_nxt  = 1'b1;
					busy_nxt = 1'b1;
					st_nxt   = ASRAM_SLEEP;
				end else if (req_i) begin
					addr_nxt = req_addr_i;
					wd_nxt   = req_wdata_i;
					busy_nxt = 1'b1;
					if (req_wr_i) begin
						// selects first, strobe later, so memory keeps outputs off
						ctl_nxt = CTL_WR;
						st_nxt  = ASRAM_WR_SETUP;
					end else begin
						// full access time counts from address and selects
						ctl_nxt = CTL_RD;
						cnt_nxt = ACC_C;
						st_nxt  = ASRAM_RD;
					end
				end
			end
			ASRAM_RD: begin
				if (rd_take) begin
					ctl_nxt  = CTL_OFF;
					cnt_nxt  = DIS_C;
					st_nxt   = ASRAM_TURN;
				end
			end
			ASRAM_WR_SETUP: begin
				ctl_nxt.we_n = 1'b0;
				cnt_nxt      = WP_C;
				st_nxt       = ASRAM_WR_PULSE;
			end
			ASRAM_WR_PULSE: begin
				// wait out memory turn-off before driving data
				// out three cycles before strobe rise for data setup, still past turn-off
				if (cnt_r == (DSU_C + CW'(1))) begin
					dqoe_nxt = 1'b1;
				end
				// strobe width covers data setup; setup cycle plus strobe covers address setup
				if (cnt_r == CW'(1)) begin
					ctl_nxt.we_n = 1'b1;
					st_nxt       = ASRAM_WR_END;
				end
			end
			ASRAM_WR_END: begin
				// data held one cycle past strobe rise, zero hold needed
				dqoe_nxt = 1'b0;
				ctl_nxt  = CTL_OFF;
				cnt_nxt  = WC_C - WP_C;
				st_nxt   = ASRAM_TURN;
			end
			ASRAM_TURN: begin
				if (cnt_r <= CW'(1)) begin
					busy_nxt = 1'b0;
					st_nxt   = ASRAM_IDLE;
				end
			end
			ASRAM_SLEEP: begin
				if (!sleep_i) begin
					cnt_nxt = REC_C;
					st_nxt  = ASRAM_WAKE;
				end
			end
			ASRAM_WAKE: begin
				// long wait: still deselected until memory has recovered
				if (cnt_r <= CW'(1)) begin
					slp_nxt  = 1'b0;
					busy_nxt = 1'b0;
					st_nxt   = ASRAM_IDLE;
				end
			end
			default: begin
				st_nxt = ASRAM_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			st_r   <= ASRAM_IDLE;
			cnt_r  <= '0;
			ctl_r  <= CTL_OFF;
			addr_r <= '0;
			wd_r   <= '0;
			dqoe_r <= 1'b0;
			busy_r <= 1'b1;
			slp_r  <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			cnt_r  <= cnt_nxt;
			ctl_r  <= ctl_nxt;
			addr_r <= addr_nxt;
			wd_r   <= wd_nxt;
			dqoe_r <= dqoe_nxt;
			busy_r <= busy_nxt;
			slp_r  <= slp_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read capture on the last access cycle; apart so the pulse never lingers
	assign rd_take = (st_r == ASRAM_RD) && (cnt_r == CW'(1));

	always_comb begin
		rdat_nxt = rdat_r;
		rval_nxt = 1'b0;
		if (rd_take) begin
			rdat_nxt = mem_dq_i;
			rval_nxt = 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			rdat_r <= '0;
			rval_r <= 1'b0;
		end else begin
			rdat_r <= rdat_nxt;
			rval_r <= rval_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign busy_o      = busy_r;
	assign rd_valid_o  = rval_r;
	assign rd_data_o   = rdat_r;
	assign asleep_o    = slp_r;
	assign mem_addr_o  = addr_r;
	assign mem_cs1_n_o = ctl_r.cs1_n;
	assign mem_cs2_o   = ctl_r.cs2;
	assign mem_we_n_o  = ctl_r.we_n;
	assign mem_oe_n_o  = ctl_r.oe_n;
	assign mem_dq_o    = wd_r;
	assign mem_dq_oe_o = dqoe_r;

endmodule

// [tb/asram_chk.sv]
`timescale 1ns/10ps
module asram_chk (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic rd_valid_o,
	input wire logic mem_cs1_n_o,
	input wire logic mem_cs2_o,
	input wire logic mem_we_n_o,
	input wire logic mem_oe_n_o,
	input wire logic mem_dq_oe_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	a_cs2_firm: assert property (mem_cs2_o) else $error("cs2");
	a_no_clash: assert property (mem_dq_oe_o |-> mem_oe_n_o) else $error("clash");
	a_dq_late: assert property ($rose(mem_dq_oe_o) |-> !$past(mem_we_n_o, 3)) else $error("dq");
	a_wr_width: assert property ($fell(mem_we_n_o) |-> !mem_we_n_o [*6] ##1 mem_we_n_o) else $error("we");
	a_wr_sel: assert property (!mem_we_n_o |-> !mem_cs1_n_o && mem_oe_n_o) else $error("wsel");
	a_wr_setup: assert property ($rose(mem_we_n_o) && !$past(sys_rst_i) |->
		mem_dq_oe_o && $past(mem_dq_oe_o, 3)) else $error("setup");
	a_sel_first: assert property ($fell(mem_we_n_o) |-> !$past(mem_cs1_n_o)) else $error("wfirst");
	a_rd_access: assert property ($fell(mem_oe_n_o) |-> !mem_oe_n_o [*8] ##1 rd_valid_o) else $error("acc");
	a_rd_turn: assert property ($rose(mem_oe_n_o) |-> mem_cs1_n_o [*3]) else $error("turn");
	cover property ($rose(rd_valid_o));
	cover property ($fell(mem_we_n_o));
	cover property ($fell(mem_cs1_n_o));
endmodule
bind asram_ctrl asram_chk chk (.*);

// [tb/asram_mem.sv]
`timescale 1ns/10ps
module asram_mem (
	input wire logic [16:0] a_i,
	input wire logic        cs1_n_i,
	input wire logic        cs2_i,
	input wire logic        we_n_i,
	input wire logic        oe_n_i,
	input wire logic [7:0]  d_i,
	output logic     [7:0]  q_o
);
	logic [7:0] mem_r [2**17];
	wire wr = !cs1_n_i && cs2_i && !we_n_i;
	wire rd = !cs1_n_i && cs2_i && we_n_i && !oe_n_i;
	initial q_o = 8'h00;
	// first ending edge stores the word
	always @(negedge wr) mem_r[a_i] = d_i;
	// data as late as allowed, old word held till then
	always @(rd, a_i)
		if (rd) q_o <= #70 mem_r[a_i];
		else q_o <= #25 ~q_o;
endmodule

// [tb/tb_async_sram_access_timing.sv]
`timescale 1ns/10ps
module tb_async_sram_access_timing;
	logic        mclk_i = 1'h0, sys_rst_i = 1'h1, req_i = 1'h0, req_wr_i = 1'h0, sleep_i = 1'h0, v;
	logic [16:0] req_addr_i = 17'h0, mem_addr_o;
	logic [7:0]  req_wdata_i = 8'h0, rd_data_o, mem_dq_o, mem_dq_i;
	logic        busy_o, rd_valid_o, asleep_o, mem_cs1_n_o, mem_cs2_o, mem_we_n_o, mem_oe_n_o, mem_dq_oe_o;
	int          error_cnt = 0, comparisons = 0, n;
	asram_ctrl #(.REC_PD_CYC(20)) uut (.*);
	// undriven bus shows the inverse, so a late capture is caught
	asram_mem mem (.a_i(mem_addr_o), .cs1_n_i(mem_cs1_n_o), .cs2_i(mem_cs2_o), .we_n_i(mem_we_n_o),
		.oe_n_i(mem_oe_n_o), .d_i(mem_dq_oe_o ? mem_dq_o : ~mem_dq_o), .q_o(mem_dq_i));
	initial forever #5 mclk_i = ~mclk_i;
	task test_done;
		if (error_cnt == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task acc(input logic w, input logic [16:0] a, input logic [7:0] d);
		@(negedge mclk_i);
		{req_i, req_wr_i, req_addr_i, req_wdata_i} = {1'h1, w, a, d};
		@(negedge mclk_i);
		req_i = 1'h0;
		n = 0;
		v = 1'h0;
		// busy rises one edge late, so never trust the first look
		do begin
			@(negedge mclk_i);
			n++;
			v |= rd_valid_o;
		end while ((busy_o || n < 2) && n < 50);
		if (n >= 50) begin
			error_cnt++;
			$display("mismatch busy expected 0 seen 1");
			test_done;
		end
	endtask
	task rd_chk(input logic [16:0] a, input logic [7:0] e);
		acc(1'h0, a, 8'h0);
		chk("rd_valid", 8'h1, {7'h0, v});
		chk("rd_data", e, rd_data_o);
	endtask
	task t_reset;
		repeat (20) @(negedge mclk_i);
		chk("busy", 8'h1, {7'h0, busy_o});
		chk("ctl", 8'h1e, {3'h0, mem_cs1_n_o, mem_cs2_o, mem_we_n_o, mem_oe_n_o, mem_dq_oe_o});
		sys_rst_i = 1'h0;
		repeat (2) @(negedge mclk_i);
	endtask
	task t_wr_rd;
		acc(1'h1, 17'h0, 8'h5a);
		acc(1'h1, 17'h1ffff, 8'ha5);
		rd_chk(17'h0, 8'h5a);
		rd_chk(17'h1ffff, 8'ha5);
		acc(1'h1, 17'h1ffff, 8'h3c);
		rd_chk(17'h1ffff, 8'h3c);
	endtask
	task t_mid_rst;
		@(negedge mclk_i);
		{req_i, req_wr_i, req_addr_i, req_wdata_i} = {1'h1, 1'h1, 17'h2, 8'h77};
		@(negedge mclk_i);
		chk("rst_sel", 8'h0, {7'h0, mem_cs1_n_o});
		{req_i, sys_rst_i} = 2'h1;
		@(negedge mclk_i);
		chk("rst_busy", 8'h1, {7'h0, busy_o});
		chk("rst_ctl", 8'h1e, {3'h0, mem_cs1_n_o, mem_cs2_o, mem_we_n_o, mem_oe_n_o, mem_dq_oe_o});
		sys_rst_i = 1'h0;
		@(negedge mclk_i);
		chk("rst_idle", 8'h0, {7'h0, busy_o});
		rd_chk(17'h1ffff, 8'h3c);
	endtask
	task t_sleep;
		sleep_i = 1'h1;
		repeat (5) @(negedge mclk_i);
		chk("asleep", 8'h1, {7'h0, asleep_o});
		chk("cs1_n", 8'h1, {7'h0, mem_cs1_n_o});
		sleep_i = 1'h0;
		n = 0;
		while (asleep_o && n < 60) begin
			@(negedge mclk_i);
			n++;
		end
		if (n >= 60) begin
			error_cnt++;
			$display("mismatch asleep expected 0 seen 1");
			test_done;
		end
		chk("wake_wait", 8'h1, {7'h0, n >= 20 && n < 60});
		rd_chk(17'h0, 8'h5a);
	endtask
	initial begin
		t_reset;
		t_wr_rd;
		t_mid_rst;
		t_sleep;
		test_done;
	end
endmodule
